// [settings_pkg.sv]
// register map, field layout and timing constants of the device-settings block
// assumes a 25 MHz core clock and a 32-bit axi4-lite register bus
package settings_pkg;
  localparam int unsigned CLK_HZ = 25000000;
  localparam logic [31:0] SETTINGS_ADDR = 32'h0000_0000;
  localparam logic [31:0] STATUS_ADDR = 32'h0000_0004;
  localparam int WORD_W = 12;
  localparam logic [11:0] SETTINGS_RESET = 12'h007;
  localparam int REV_GUARD_BIT = 11;
  localparam int BLIND_HIGH_BIT = 10;
  localparam int BLIND_LOW_BIT = 9;
  localparam int DIAG_TEN_BIT = 2;
  localparam int DIAG_NINE_BIT = 1;
  localparam int DIAG_LOW_BIT = 0;
  localparam int unsigned FILTER_US = 150;
  localparam int unsigned BLIND_SHORT_US = 2500;
  localparam int unsigned BLIND_LONG_US = 5000;
  localparam int unsigned FILTER_CYC = FILTER_US * (CLK_HZ / 1000000);
  localparam int unsigned BLIND_SHORT_CYC = BLIND_SHORT_US * (CLK_HZ / 1000000);
  localparam int unsigned BLIND_LONG_CYC = BLIND_LONG_US * (CLK_HZ / 1000000);
  localparam int CNT_W = 18;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : settings_pkg

// [device_settings_regs.sv]
// device-settings word behind an axi4-lite slave, with the blind-time
// timer for channels 7 to 10 and per-channel diagnosis enables.
// assumes one clock domain; diagnosis start events come from the same clock.
// How it works
// - after reset the settings word is 0x007.
// - bit 11 turns the reverse-current comparator on for all channels.
// - blind-time field bits 10:9 only shape timing of channels 7 to 10.
// - lower blind bit clear gives the 150 us standard filter time.
// - lower blind bit set gives 2.5 ms, or 5 ms with upper bit set.
// - bits 2:0 can switch diagnosis currents off so lamps do not glow.
// - bit 0 governs channels 1-8, bit 1 channel 9, bit 2 channel 10.
// - cleared bit stops open-load/short-to-ground sensing; overload sensing stays.
module device_settings_regs
  import settings_pkg::*;
#(
  parameter int unsigned FILTER_CYCLES = FILTER_CYC,
  parameter int unsigned BLIND_SHORT_CYCLES = BLIND_SHORT_CYC,
  parameter int unsigned BLIND_LONG_CYCLES = BLIND_LONG_CYC
)
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic upper_off_start,
  output logic reverse_current_guard_enable,
  output logic [9:0] off_diag_enable,
  output logic [9:0] diag_current_enable,
  output logic [9:0] on_diag_enable,
  output logic upper_blind_active
);

  logic [11:0] settings_r;
  logic [11:0] settings_nxt;
  logic aw_held_r;
  logic aw_held_nxt;
  logic [31:0] aw_addr_r;
  logic [31:0] aw_addr_nxt;
  logic w_held_r;
  logic w_held_nxt;
  logic [31:0] w_data_r;
  logic [31:0] w_data_nxt;
  logic [3:0] w_strb_r;
  logic [3:0] w_strb_nxt;
  logic bvalid_r;
  logic bvalid_nxt;
  logic [1:0] bresp_r;
  logic [1:0] bresp_nxt;
  logic rvalid_r;
  logic rvalid_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic [1:0] rresp_r;
  logic [1:0] rresp_nxt;
  logic [CNT_W-1:0] blind_cnt_r;
  logic [CNT_W-1:0] blind_cnt_nxt;
  logic [CNT_W-1:0] blind_load;
  logic do_write;
  logic blind_active_r;
  logic blind_active_nxt;
  typedef enum logic [1:0] {SLOT_SETTINGS, SLOT_STATUS, SLOT_NONE} slot_type;

  // byte-lane merge, used for both lanes of the 12-bit word
  function automatic logic [11:0] merge_word(input logic [11:0] old_word,
                                             input logic [31:0] data,
                                             input logic [3:0] strb);
    logic [11:0] result;
    result = old_word;
    if (strb[0])
    begin
      result[7:0] = data[7:0];
    end
    if (strb[1])
    begin
      result[11:8] = data[11:8];
    end
    return result;
  endfunction : merge_word

  // one decoder for both paths, so reads and writes never disagree on the map
  function automatic slot_type decode_slot(input logic [31:0] addr);
    slot_type slot;
    if (addr == SETTINGS_ADDR)
    begin
      slot = SLOT_SETTINGS;
    end
    else if (addr == STATUS_ADDR)
    begin
      slot = SLOT_STATUS;
    end
    else
    begin
      slot = SLOT_NONE;
    end
    return slot;
  endfunction : decode_slot

  // a new write waits until the response is taken, so only one is ever in flight
  assign s_axi_awready = !aw_held_r && !bvalid_r;
  assign s_axi_wready = !w_held_r && !bvalid_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign do_write = aw_held_r && w_held_r && !bvalid_r;

  // write path: address and data may arrive in either order
  always_comb
  begin
    aw_held_nxt = aw_held_r;
    aw_addr_nxt = aw_addr_r;
    w_held_nxt = w_held_r;
    w_data_nxt = w_data_r;
    w_strb_nxt = w_strb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    settings_nxt = settings_r;
    if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held_nxt = 1'b1;
      aw_addr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      w_held_nxt = 1'b1;
      w_data_nxt = s_axi_wdata;
      w_strb_nxt = s_axi_wstrb;
    end
    if (do_write)
    begin
      aw_held_nxt = 1'b0;
      w_held_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      unique case (decode_slot(aw_addr_r))
        SLOT_SETTINGS:
        begin
          // reserved and unused bits are stored as written; the host clears bits 7:3 but not bit 8
          settings_nxt = merge_word(settings_r, w_data_r, w_strb_r);
          bresp_nxt = RESP_OKAY;
        end
        SLOT_STATUS:
        begin
          bresp_nxt = RESP_OKAY;
        end
        SLOT_NONE:
        begin
          bresp_nxt = RESP_SLVERR;
        end
      endcase
    end
    else if (bvalid_r && s_axi_bready)
    begin
      bvalid_nxt = 1'b0;
    end
  end

  // read path: one read in flight, answered the cycle after the address is taken
  always_comb
  begin
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_nxt = 1'b1;
      rresp_nxt = RESP_OKAY;
      unique case (decode_slot(s_axi_araddr))
        SLOT_SETTINGS:
        begin
          rdata_nxt = {20'h0_0000, settings_r};
        end
        SLOT_STATUS:
        begin
          rdata_nxt = {31'h0000_0000, upper_blind_active};
        end
        SLOT_NONE:
        begin
          rdata_nxt = 32'h0000_0000;
          rresp_nxt = RESP_SLVERR;
        end
      endcase
    end
    else if (rvalid_r && s_axi_rready)
    begin
      rvalid_nxt = 1'b0;
    end
  end

  // blind or filter window for channels 7 to 10 only
  always_comb
  begin
    if (!settings_r[BLIND_LOW_BIT])
    begin
      blind_load = CNT_W'(FILTER_CYCLES);
    end
    else if (settings_r[BLIND_HIGH_BIT])
    begin
      blind_load = CNT_W'(BLIND_LONG_CYCLES);
    end
    else
    begin
      blind_load = CNT_W'(BLIND_SHORT_CYCLES);
    end
    blind_cnt_nxt = blind_cnt_r;
    if (upper_off_start)
    begin
      blind_cnt_nxt = blind_load;
    end
    else if (blind_cnt_r != '0)
    begin
      blind_cnt_nxt = blind_cnt_r - CNT_W'(1);
    end
    // registered so the output cannot glitch while the count ripples down
    blind_active_nxt = (blind_cnt_nxt != '0);
  end

  assign upper_blind_active = blind_active_r;
  assign reverse_current_guard_enable = settings_r[REV_GUARD_BIT];

  // channels 1-8 share one bit; 9 and 10 each have their own
  always_comb
  begin
    diag_current_enable = {settings_r[DIAG_TEN_BIT], settings_r[DIAG_NINE_BIT],
                           {8{settings_r[DIAG_LOW_BIT]}}};
    off_diag_enable = diag_current_enable;
    on_diag_enable = 10'h3FF;
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      settings_r <= SETTINGS_RESET;
      aw_held_r <= 1'b0;
      aw_addr_r <= 32'h0000_0000;
      w_held_r <= 1'b0;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= 2'h0;
    end
    else
    begin
      settings_r <= settings_nxt;
      aw_held_r <= aw_held_nxt;
      aw_addr_r <= aw_addr_nxt;
      w_held_r <= w_held_nxt;
      w_data_r <= w_data_nxt;
      w_strb_r <= w_strb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
    end
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= 2'h0;
    end
    else
    begin
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
    end
  end

  // a reset also ends any blind window that was running
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      blind_cnt_r <= '0;
      blind_active_r <= 1'b0;
    end
    else
    begin
      blind_cnt_r <= blind_cnt_nxt;
      blind_active_r <= blind_active_nxt;
    end
  end

endmodule : device_settings_regs

// [device_settings_regs_sva.sv]
// port-level checks of the device-settings block
// sees only the block's ports; attached by bind
module device_settings_regs_sva
(
  input logic core_clk,
  input logic resetn,
  input logic upper_off_start,
  input logic upper_blind_active,
  input logic reverse_current_guard_enable,
  input logic [9:0] diag_current_enable,
  input logic [9:0] off_diag_enable,
  input logic [9:0] on_diag_enable
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);
  guard_reset_a: assert property ($rose(resetn) |-> !reverse_current_guard_enable)
    else $error("guard set at reset");
  diag_reset_a: assert property ($rose(resetn) |-> &diag_current_enable)
    else $error("diag off at reset");
  group_map_a: assert property (diag_current_enable[7:0] == {8{diag_current_enable[0]}})
    else $error("group split");
  off_diag_a: assert property (off_diag_enable == diag_current_enable)
    else $error("off diag mismatch");
  on_diag_a: assert property (on_diag_enable == 10'h3FF)
    else $error("on diag off");
  blind_start_a: assert property (upper_off_start |=> upper_blind_active)
    else $error("blind not started");
  blind_min_a: assert property ($rose(upper_blind_active) |-> upper_blind_active [*5])
    else $error("blind too short");
  blind_idle_a:
    assert property (!upper_off_start && !upper_blind_active |=> !upper_blind_active)
    else $error("blind self started");
endmodule : device_settings_regs_sva
bind device_settings_regs device_settings_regs_sva i_device_settings_regs_sva (.*);

// [host_model.sv]
// host side: axi4-lite master, one command at a time
// tasks start one edge after the call so strobes never toggle twice
module host_model
(
  input logic core_clk,
  output logic [31:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input logic s_axi_wready,
  input logic [1:0] s_axi_bresp,
  input logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [31:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input logic s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic [1:0] s_axi_rresp,
  input logic s_axi_rvalid,
  output logic s_axi_rready
);
  initial
  begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    s_axi_wstrb = 4'hF;
  end
  task automatic wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r,
                    input logic [3:0] s = 4'hF);
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d & 32'hFFFF_FF07;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge core_clk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    r = s_axi_bresp;
  endtask : wr
  task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge core_clk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask : rd
endmodule : host_model

// [device_settings_regs_tb.sv]
// bench for the device-settings block with blind counts cut to 5, 10, 20
// host_model drives the bus; the bench pulses the blind start
module device_settings_regs_tb
  import settings_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk, resetn, upper_off_start, upper_blind_active, reverse_current_guard_enable;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rd_v;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [3:0] s_axi_wstrb;
  logic [9:0] off_diag_enable, diag_current_enable, on_diag_enable;
  int err_total, checked, cyc;
  device_settings_regs #(.FILTER_CYCLES(5), .BLIND_SHORT_CYCLES(10), .BLIND_LONG_CYCLES(20))
    i_device_settings_regs (.*);
  host_model i_host_model (.*);
  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    checked++;
    if (s !== e)
    begin
      err_total++;
      $display("unexpected %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task automatic close_out;
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out
  task automatic t_fields;
    logic [11:0] v [4] = '{12'h802, 12'h004, 12'h001, 12'h000};
    i_host_model.rd(SETTINGS_ADDR, rd_v, rsp);
    chk("reset", 32'(SETTINGS_RESET), rd_v);
    chk("rresp", 32'(RESP_OKAY), 32'(rsp));
    foreach (v[k])
    begin
      i_host_model.wr(SETTINGS_ADDR, 32'(v[k]), rsp);
      chk("wresp", 32'(RESP_OKAY), 32'(rsp));
      i_host_model.rd(SETTINGS_ADDR, rd_v, rsp);
      chk("word", 32'(v[k]), rd_v);
      chk("guard", 32'(v[k][11]), 32'(reverse_current_guard_enable));
      chk("diag", 32'({v[k][2:1], {8{v[k][0]}}}), 32'(diag_current_enable));
      chk("off diag", 32'({v[k][2:1], {8{v[k][0]}}}), 32'(off_diag_enable));
      chk("on diag", 32'h0000_03FF, 32'(on_diag_enable));
    end
    $display("t_fields end");
  endtask : t_fields
  task automatic t_blind;
    int n;
    for (int k = 0; k < 4; k++)
    begin
      i_host_model.wr(SETTINGS_ADDR, {21'h0, 2'(k), 9'h007}, rsp);
      upper_off_start <= 1'b1;
      @(posedge core_clk);
      upper_off_start <= 1'b0;
      n = 0;
      repeat (30)
      begin
        @(posedge core_clk);
        if (upper_blind_active === 1'b1)
          n++;
      end
      chk("blind", k[0] ? (k[1] ? 20 : 10) : 5, n);
    end
    $display("t_blind end");
  endtask : t_blind
  task automatic t_unmapped;
    i_host_model.wr(32'h0000_0008, 32'h0000_0800, rsp);
    chk("resp", 32'(RESP_SLVERR), 32'(rsp));
    i_host_model.rd(SETTINGS_ADDR, rd_v, rsp);
    chk("kept", 32'h0000_0607, rd_v);
    i_host_model.rd(32'h0000_0008, rd_v, rsp);
    chk("rd resp", 32'(RESP_SLVERR), 32'(rsp));
    chk("rd data", 32'h0000_0000, rd_v);
    i_host_model.wr(STATUS_ADDR, 32'h0000_0001, rsp);
    chk("status resp", 32'(RESP_OKAY), 32'(rsp));
    i_host_model.rd(SETTINGS_ADDR, rd_v, rsp);
    chk("status wr", 32'h0000_0607, rd_v);
    upper_off_start <= 1'b1;
    @(posedge core_clk);
    upper_off_start <= 1'b0;
    i_host_model.rd(STATUS_ADDR, rd_v, rsp);
    chk("status on", 32'h0000_0001, rd_v);
    repeat (25) @(posedge core_clk);
    i_host_model.rd(STATUS_ADDR, rd_v, rsp);
    chk("status off", 32'h0000_0000, rd_v);
    i_host_model.wr(SETTINGS_ADDR, 32'h0000_0800, rsp, 4'h1);
    i_host_model.rd(SETTINGS_ADDR, rd_v, rsp);
    chk("lane0", 32'h0000_0600, rd_v);
    i_host_model.wr(SETTINGS_ADDR, 32'h0000_0807, rsp, 4'h2);
    i_host_model.rd(SETTINGS_ADDR, rd_v, rsp);
    chk("lane1", 32'h0000_0800, rd_v);
    $display("t_unmapped end");
  endtask : t_unmapped
  task automatic t_rereset;
    i_host_model.wr(SETTINGS_ADDR, 32'h0000_0E00, rsp);
    chk("guard on", 32'h0000_0001, 32'(reverse_current_guard_enable));
    upper_off_start <= 1'b1;
    @(posedge core_clk);
    upper_off_start <= 1'b0;
    resetn <= 1'b0;
    @(posedge core_clk);
    resetn <= 1'b1;
    i_host_model.rd(SETTINGS_ADDR, rd_v, rsp);
    chk("rereset", 32'(SETTINGS_RESET), rd_v);
    chk("guard off", 32'h0000_0000, 32'(reverse_current_guard_enable));
    chk("diag on", 32'h0000_03FF, 32'(diag_current_enable));
    chk("blind off", 32'h0000_0000, 32'(upper_blind_active));
    $display("t_rereset end");
  endtask : t_rereset
  initial
  begin
    resetn = 1'b0;
    upper_off_start = 1'b0;
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    t_fields();
    t_blind();
    t_unmapped();
    t_rereset();
    close_out();
  end
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      err_total++;
      close_out();
    end
  end
endmodule : device_settings_regs_tb
